// File: shared/sas_defs.vh
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// ----------------------------------------
// register word addresses (byte address = 4 * index)
// ----------------------------------------
`define SAS_REG_CTRL      4'h0
`define SAS_REG_STATUS    4'h1
`define SAS_REG_INT_STAT  4'h2
`define SAS_REG_INT_EN    4'h3
`define SAS_REG_INT_CLR   4'h4
`define SAS_REG_LP_CTRL   4'h5
`define SAS_REG_LP1_RES   4'h6
`define SAS_REG_LP2_RES   4'h7
`define SAS_REG_LAST_WORD 4'h8
`define SAS_TABLE_SEL     5

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SAS_CTRL_START    0
`define SAS_CTRL_STOP     1
`define SAS_CTRL_ROUTE    2
`define SAS_CTRL_TRIG_EN  3
`define SAS_CTRL_MODE_LO  4
`define SAS_CTRL_MODE_HI  5
`define SAS_CTRL_CONV     6
`define SAS_CTRL_LEN_LO   8
`define SAS_CTRL_LEN_HI   11
`define SAS_CTRL_ROUNDS_LO 16
`define SAS_CTRL_ROUNDS_HI 23
`define SAS_CTRL_RESET    32'h0000_0f00

// ----------------------------------------
// scan modes
// ----------------------------------------
`define SAS_MODE_SINGLE   2'h0
`define SAS_MODE_DOUBLE   2'h1
`define SAS_MODE_ALTER    2'h2

// ----------------------------------------
// table entry fields
// ----------------------------------------
`define SAS_ENT_CH_HI     7
`define SAS_ENT_CH_LO     4
`define SAS_ENT_RES_HI    3
`define SAS_ENT_RES_LO    2
`define SAS_ENT_ATT_HI    1
`define SAS_ENT_ATT_LO    0

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define SAS_INT_SCAN_DONE 0
`define SAS_INT_LP1_DONE  1
`define SAS_INT_LP2_DONE  2
`define SAS_INT_OVERRUN   3

// ----------------------------------------
// low-power control fields
// ----------------------------------------
`define SAS_LP_START1     0
`define SAS_LP_START2     1
`define SAS_LP_CH1_LO     4
`define SAS_LP_CH2_LO     8

`endif

// File: rtl/sas_lp_ctrl.v
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// low-power single-conversion controller
// ----------------------------------------
// one conversion per start pulse; no scanning, no dma
module sas_lp_ctrl (
    input wire i_clock,          // system clock
    input wire i_rst_n,          // synchronised reset, active low
    input wire i_start,          // conversion start pulse
    input wire [3:0] i_channel,  // channel to convert
    output reg o_conv_req,       // request to converter
    output reg [3:0] o_conv_ch,  // channel to converter
    input wire i_conv_done,      // converter finished pulse
    input wire [11:0] i_conv_data, // converter result
    output reg [11:0] o_result,  // held result
    output reg o_busy,           // conversion pending
    output reg o_done            // result captured pulse
);

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conv_req <= 1'b0;
            o_conv_ch <= 4'h0;
            o_result <= 12'h000;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_conv_req <= 1'b0;
            if (!o_busy && i_start) begin
                o_conv_req <= 1'b1;
                o_conv_ch <= i_channel;
                o_busy <= 1'b1;
            end else if (o_busy && i_conv_done) begin
                o_result <= i_conv_data;
                o_busy <= 1'b0;
                o_done <= 1'b1;
            end
        end
    end

endmodule // sas_lp_ctrl

`default_nettype wire

// File: rtl/sas_scan_top.v
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sas_defs.vh"

module sas_scan_top (
    input wire i_clock,             // 20 mhz clock
    input wire i_nrst,              // async reset, active low
    input wire [7:0] i_address,     // avalon word address
    input wire i_read,              // avalon read
    input wire i_write,             // avalon write
    input wire [31:0] i_writedata,  // avalon write data
    input wire [3:0] i_byteenable,  // avalon byte enables
    output reg [31:0] o_readdata,   // avalon read data
    output reg o_waitrequest,       // avalon wait
    output reg o_irq,               // level interrupt
    input wire i_ws,                // serial-port word select
    output reg [15:0] o_dma_word,   // packed result word
    output reg o_dma_valid,         // result ready pulse
    output reg o_conv1_req,         // converter one start pulse
    output reg o_conv2_req,         // converter two start pulse
    output reg [7:0] o_conv1_entry, // converter one entry
    output reg [7:0] o_conv2_entry, // converter two entry
    input wire i_conv1_done,        // converter one done pulse
    input wire i_conv2_done,        // converter two done pulse
    input wire [11:0] i_conv1_data, // converter one result
    input wire [11:0] i_conv2_data, // converter two result
    input wire i_lp_start1,         // coproc start one
    input wire i_lp_start2,         // coproc start two
    input wire i_deep_sleep,        // deep sleep
    output reg o_lp1_req,           // low-power one start
    output reg o_lp2_req,           // low-power two start
    output reg [3:0] o_lp1_ch,      // low-power one channel
    output reg [3:0] o_lp2_ch,      // low-power two channel
    input wire i_lp1_done,          // low-power one done
    input wire i_lp2_done,          // low-power two done
    input wire [11:0] i_lp1_data,   // low-power one data
    input wire [11:0] i_lp2_data    // low-power two data
);

    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // result trimmed to the entry resolution: 0=9 bit .. 3=12 bit
    function [11:0] sas_trim;
        input [11:0] data;
        input [1:0] res;
        begin
            case (res)
                2'h0: sas_trim = {data[11:3], 3'h0};
                2'h1: sas_trim = {data[11:2], 2'h0};
                2'h2: sas_trim = {data[11:1], 1'h0};
                default: sas_trim = data;
            endcase
        end
    endfunction

    function [15:0] sas_pack;
        input [1:0] mode;
        input sel;
        input [7:0] entry;
        input [11:0] data;
        reg [11:0] t;
        begin
            t = sas_trim(data, entry[`SAS_ENT_RES_HI:`SAS_ENT_RES_LO]);
            if (mode == `SAS_MODE_SINGLE)
                sas_pack = {entry[`SAS_ENT_CH_HI:`SAS_ENT_CH_LO], t};
            else
                sas_pack = {sel, entry[`SAS_ENT_CH_HI:`SAS_ENT_CH_LO], t[11:1]};
        end
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [31:0] ctrl_q;
    reg [3:0] int_stat_q;
    reg [3:0] int_en_q;
    reg [7:0] table1_q [0:15];
    reg [7:0] table2_q [0:15];
    reg [15:0] last_word_q;
    reg ws_q;
    reg start_sw_q;
    reg lp_start1_q;
    reg lp_start2_q;
    reg [3:0] lp_ch1_q;
    reg [3:0] lp_ch2_q;

    wire [1:0] mode = ctrl_q[`SAS_CTRL_MODE_HI:`SAS_CTRL_MODE_LO];
    wire [3:0] last_idx = ctrl_q[`SAS_CTRL_LEN_HI:`SAS_CTRL_LEN_LO];
    wire [7:0] rounds = ctrl_q[`SAS_CTRL_ROUNDS_HI:`SAS_CTRL_ROUNDS_LO];
    wire route_on = ctrl_q[`SAS_CTRL_ROUTE];
    wire ws_edge = i_ws != ws_q;

    // ----------------------------------------
    // scan state machine
    // ----------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    reg [1:0] state_q;
    reg [3:0] idx_q;
    reg [7:0] round_q;
    reg sel_q;
    reg got1_q;
    reg got2_q;
    reg [11:0] hold2_q;
    reg stop_req;
    reg done_evt;
    reg overrun_evt;

    // a trigger launches a scan; word-select edges then pace measurements
    wire trig_start = ctrl_q[`SAS_CTRL_TRIG_EN] && route_on && ws_edge;
    wire scan_start = start_sw_q || trig_start;
    wire step_go = route_on ? ws_edge : 1'b1;
    wire need1 = (mode == `SAS_MODE_DOUBLE) || (mode == `SAS_MODE_ALTER && !sel_q)
                 || (mode == `SAS_MODE_SINGLE && !ctrl_q[`SAS_CTRL_CONV]);
    wire need2 = !need1 || mode == `SAS_MODE_DOUBLE;
    wire have1 = got1_q || i_conv1_done;
    wire have2 = got2_q || i_conv2_done;
    wire conv_end = (!need1 || have1) && (!need2 || have2);
    // double mode: converter two word is the one sent
    wire use1 = need1 && mode != `SAS_MODE_DOUBLE;
    wire [11:0] res2 = got2_q ? hold2_q : i_conv2_data;
    wire [15:0] pk_word = use1 ? sas_pack(mode, 1'b0, o_conv1_entry, i_conv1_data)
                               : sas_pack(mode, 1'b1, o_conv2_entry, res2);

    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            idx_q <= 4'h0;
            round_q <= 8'h00;
            sel_q <= 1'b0;
            got1_q <= 1'b0;
            got2_q <= 1'b0;
            hold2_q <= 12'h000;
            o_conv1_req <= 1'b0;
            o_conv2_req <= 1'b0;
            o_conv1_entry <= 8'h00;
            o_conv2_entry <= 8'h00;
            o_dma_word <= 16'h0000;
            o_dma_valid <= 1'b0;
            last_word_q <= 16'h0000;
            done_evt <= 1'b0;
            overrun_evt <= 1'b0;
        end else begin
            o_conv1_req <= 1'b0;
            o_conv2_req <= 1'b0;
            o_dma_valid <= 1'b0;
            done_evt <= 1'b0;
            overrun_evt <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (scan_start) begin
                        idx_q <= 4'h0;
                        round_q <= 8'h00;
                        sel_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (stop_req) begin
                        state_q <= ST_IDLE;
                    end else if (step_go) begin
                        o_conv1_req <= need1;
                        o_conv2_req <= need2;
                        o_conv1_entry <= table1_q[idx_q];
                        o_conv2_entry <= table2_q[idx_q];
                        got1_q <= 1'b0;
                        got2_q <= 1'b0;
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (route_on && ws_edge)
                        overrun_evt <= 1'b1;
                    if (i_conv1_done)
                        got1_q <= 1'b1;
                    if (i_conv2_done) begin
                        got2_q <= 1'b1;
                        hold2_q <= i_conv2_data;
                    end
                    if (conv_end) begin
                        last_word_q <= pk_word;
                        o_dma_word <= pk_word;
                        o_dma_valid <= route_on;
                        if (mode == `SAS_MODE_ALTER)
                            sel_q <= ~sel_q;
                        state_q <= ST_WAIT;
                        if (idx_q == last_idx) begin
                            idx_q <= 4'h0;
                            round_q <= round_q + 8'h01;
                            if (round_q + 8'h01 == rounds) begin
                                done_evt <= 1'b1;
                                state_q <= ST_IDLE;
                            end
                        end else begin
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // low-power controllers
    // ----------------------------------------
    // deep sleep hands start ownership to the coprocessor alone
    wire lp_go1 = i_deep_sleep ? i_lp_start1 : (lp_start1_q || i_lp_start1);
    wire lp_go2 = i_deep_sleep ? i_lp_start2 : (lp_start2_q || i_lp_start2);
    wire lp1_req_w;
    wire lp2_req_w;
    wire [3:0] lp1_ch_w;
    wire [3:0] lp2_ch_w;
    wire [11:0] lp1_res;
    wire [11:0] lp2_res;
    wire lp1_busy;
    wire lp2_busy;
    wire lp1_done_evt;
    wire lp2_done_evt;

    sas_lp_ctrl u_lp1 (
        .i_clock(i_clock),
        .i_rst_n(rst_n_q),
        .i_start(lp_go1),
        .i_channel(lp_ch1_q),
        .o_conv_req(lp1_req_w),
        .o_conv_ch(lp1_ch_w),
        .i_conv_done(i_lp1_done),
        .i_conv_data(i_lp1_data),
        .o_result(lp1_res),
        .o_busy(lp1_busy),
        .o_done(lp1_done_evt)
    );

    sas_lp_ctrl u_lp2 (
        .i_clock(i_clock),
        .i_rst_n(rst_n_q),
        .i_start(lp_go2),
        .i_channel(lp_ch2_q),
        .o_conv_req(lp2_req_w),
        .o_conv_ch(lp2_ch_w),
        .i_conv_done(i_lp2_done),
        .i_conv_data(i_lp2_data),
        .o_result(lp2_res),
        .o_busy(lp2_busy),
        .o_done(lp2_done_evt)
    );

    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_lp1_req <= 1'b0;
            o_lp2_req <= 1'b0;
            o_lp1_ch <= 4'h0;
            o_lp2_ch <= 4'h0;
        end else begin
            o_lp1_req <= lp1_req_w;
            o_lp2_req <= lp2_req_w;
            o_lp1_ch <= lp1_ch_w;
            o_lp2_ch <= lp2_ch_w;
        end
    end

    // ----------------------------------------
    // avalon slave and interrupts
    // ----------------------------------------
    // one wait cycle: request taken when waitrequest is low
    wire access = (i_read || i_write) && o_waitrequest;
    wire tbl = i_address[`SAS_TABLE_SEL];
    wire tbl2 = i_address[4];
    wire [3:0] widx = i_address[3:0];
    wire [3:0] evt = {overrun_evt, lp2_done_evt, lp1_done_evt, done_evt};
    wire wr_go = i_write && !o_waitrequest;
    wire [3:0] clr = (wr_go && !tbl && widx == `SAS_REG_INT_CLR && i_byteenable[0])
                     ? i_writedata[3:0] : 4'h0;
    reg [31:0] rd_d;
    integer k;

    always @* begin
        rd_d = 32'h0000_0000;
        if (tbl)
            rd_d = {24'h0, tbl2 ? table2_q[widx] : table1_q[widx]};
        else begin
            case (widx)
                `SAS_REG_CTRL: rd_d = ctrl_q;
                `SAS_REG_STATUS: rd_d = {16'h0, round_q, idx_q, lp2_busy, lp1_busy, state_q};
                `SAS_REG_INT_STAT: rd_d = {28'h0, int_stat_q};
                `SAS_REG_INT_EN: rd_d = {28'h0, int_en_q};
                `SAS_REG_LP_CTRL: rd_d = {20'h0, lp_ch2_q, lp_ch1_q, 4'h0};
                `SAS_REG_LP1_RES: rd_d = {20'h0, lp1_res};
                `SAS_REG_LP2_RES: rd_d = {20'h0, lp2_res};
                `SAS_REG_LAST_WORD: rd_d = {16'h0, last_word_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge i_clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0000_0000;
            o_irq <= 1'b0;
            ctrl_q <= `SAS_CTRL_RESET;
            int_stat_q <= 4'h0;
            int_en_q <= 4'h0;
            ws_q <= 1'b0;
            start_sw_q <= 1'b0;
            stop_req <= 1'b0;
            lp_start1_q <= 1'b0;
            lp_start2_q <= 1'b0;
            lp_ch1_q <= 4'h0;
            lp_ch2_q <= 4'h0;
            for (k = 0; k < 16; k = k + 1) begin
                table1_q[k] <= 8'h00;
                table2_q[k] <= 8'h00;
            end
        end else begin
            ws_q <= i_ws;
            start_sw_q <= 1'b0;
            stop_req <= 1'b0;
            lp_start1_q <= 1'b0;
            lp_start2_q <= 1'b0;
            o_waitrequest <= !access;
            if (access)
                o_readdata <= rd_d;
            int_stat_q <= (int_stat_q & ~clr) | evt; // set wins over clear
            o_irq <= |(((int_stat_q & ~clr) | evt) & int_en_q);
            if (wr_go && tbl && i_byteenable[0]) begin
                if (tbl2)
                    table2_q[widx] <= i_writedata[7:0];
                else
                    table1_q[widx] <= i_writedata[7:0];
            end
            if (wr_go && !tbl && widx == `SAS_REG_CTRL) begin
                if (i_byteenable[0]) begin
                    ctrl_q[7:2] <= i_writedata[7:2];
                    start_sw_q <= i_writedata[`SAS_CTRL_START];
                    stop_req <= i_writedata[`SAS_CTRL_STOP];
                end
                if (i_byteenable[1])
                    ctrl_q[15:8] <= i_writedata[15:8];
                if (i_byteenable[2])
                    ctrl_q[23:16] <= i_writedata[23:16];
            end
            if (wr_go && !tbl && widx == `SAS_REG_INT_EN && i_byteenable[0])
                int_en_q <= i_writedata[3:0];
            if (wr_go && !tbl && widx == `SAS_REG_LP_CTRL) begin
                if (i_byteenable[0]) begin
                    lp_start1_q <= i_writedata[`SAS_LP_START1] && !i_deep_sleep;
                    lp_start2_q <= i_writedata[`SAS_LP_START2] && !i_deep_sleep;
                    lp_ch1_q <= i_writedata[7:4];
                end
                if (i_byteenable[1])
                    lp_ch2_q <= i_writedata[11:8];
            end
        end
    end

endmodule // sas_scan_top

`default_nettype wire

// File: testbench/sas_scan_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module sas_scan_top_properties (
    input wire logic i_clock, // clock
    input wire logic i_nrst, // reset
    input wire logic i_read, // read
    input wire logic i_write, // write
    input wire logic o_waitrequest, // wait
    input wire logic o_dma_valid, // strobe
    input wire logic i_conv1_done, // done one
    input wire logic i_conv2_done, // done two
    input wire logic o_conv1_req, // start one
    input wire logic o_conv2_req, // start two
    input wire logic o_lp1_req, // lp start one
    input wire logic o_lp2_req // lp start two
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence bus_raised;
        (i_read || i_write) && !$past(i_read || i_write);
    endsequence
    sequence conv_finished;
        $past(i_conv1_done || i_conv2_done);
    endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    req_answer_a: assert property (bus_raised |=> !o_waitrequest)
        else $error("request unanswered");
    wait_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("wait low too long");
    wait_cause_a: assert property ($fell(o_waitrequest) |-> $past(i_read || i_write))
        else $error("wait dropped unasked");
    dma_pulse_a: assert property (o_dma_valid |=> !o_dma_valid)
        else $error("strobe too long");
    dma_cause_a: assert property (o_dma_valid |-> conv_finished)
        else $error("strobe without result");
    conv1_pulse_a: assert property (o_conv1_req |=> !o_conv1_req)
        else $error("start one too long");
    conv2_pulse_a: assert property (o_conv2_req |=> !o_conv2_req)
        else $error("start two too long");
    lp1_pulse_a: assert property (o_lp1_req |=> !o_lp1_req)
        else $error("lp start one too long");
    lp2_pulse_a: assert property (o_lp2_req |=> !o_lp2_req)
        else $error("lp start two too long");
endmodule // sas_scan_top_properties
`default_nettype wire

// File: testbench/sas_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// converter stand-in, answers DELAY cycles after each start
// ----------------------------------------
module sas_conv_model #(
    parameter int DELAY = 3
) (
    input wire logic i_clock,       // system clock
    input wire logic i_req,         // start pulse
    input wire logic [7:0] i_entry, // entry to convert
    output logic o_done,            // result pulse
    output logic [11:0] o_data      // result, valid with done
);
    int cnt = 0;
    logic [7:0] ent_q = 8'h00;
    initial o_done = 1'b0;
    initial o_data = 12'h000;
    always @(posedge i_clock) begin
        o_done <= 1'b0;
        // data garbled outside done
        o_data <= ~o_data;
        if (i_req) begin
            cnt <= DELAY;
            ent_q <= i_entry;
        end else if (cnt == 1) begin
            o_done <= 1'b1;
            o_data <= {ent_q, ent_q[7:4]} ^ 12'h5a3;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // sas_conv_model
`default_nettype wire

// File: testbench/tb_sas_scan_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sas_defs.vh"
`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("mismatch at %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module tb_sas_scan_top;
    logic clock, nrst, rd_s, wr_s, ws, deep, lps2, irq_on, wait_s, irq, dma_valid;
    logic c1req, c2req, c1done, c2done, lp1req, lp2req, lp1done, lp2done;
    logic [7:0] addr, c1ent, c2ent, tab1 [16], tab2 [16];
    logic [31:0] wdata, q, rdata;
    logic [31:0] seed = 32'hf846d06c;
    logic [15:0] dma_word;
    logic [11:0] c1data, c2data, lp1data, lp2data;
    logic [3:0] lp1ch, lp2ch, be;
    logic [15:0] got [$];
    int num_errors = 0, checks_done = 0, c1 = 0, c2 = 0, n1 = 0, n2 = 0, b;
    sas_scan_top sas_scan_top_i (.i_clock(clock), .i_nrst(nrst), .i_address(addr),
        .i_read(rd_s), .i_write(wr_s), .i_writedata(wdata), .i_byteenable(be),
        .o_readdata(rdata), .o_waitrequest(wait_s), .o_irq(irq), .i_ws(ws),
        .o_dma_word(dma_word), .o_dma_valid(dma_valid), .o_conv1_req(c1req),
        .o_conv2_req(c2req), .o_conv1_entry(c1ent), .o_conv2_entry(c2ent),
        .i_conv1_done(c1done), .i_conv2_done(c2done), .i_conv1_data(c1data),
        .i_conv2_data(c2data), .i_lp_start1(lps2), .i_lp_start2(lps2), .i_deep_sleep(deep),
        .o_lp1_req(lp1req), .o_lp2_req(lp2req), .o_lp1_ch(lp1ch), .o_lp2_ch(lp2ch),
        .i_lp1_done(lp1done), .i_lp2_done(lp2done), .i_lp1_data(lp1data),
        .i_lp2_data(lp2data));
    // prompt and slow converters on purpose
    sas_conv_model #(.DELAY(3)) sas_conv_model_c1_i (.i_clock(clock), .i_req(c1req),
        .i_entry(c1ent), .o_done(c1done), .o_data(c1data));
    sas_conv_model #(.DELAY(7)) sas_conv_model_c2_i (.i_clock(clock), .i_req(c2req),
        .i_entry(c2ent), .o_done(c2done), .o_data(c2data));
    sas_conv_model #(.DELAY(2)) sas_conv_model_l1_i (.i_clock(clock), .i_req(lp1req),
        .i_entry({lp1ch, 4'h0}), .o_done(lp1done), .o_data(lp1data));
    sas_conv_model #(.DELAY(5)) sas_conv_model_l2_i (.i_clock(clock), .i_req(lp2req),
        .i_entry({lp2ch, 4'h0}), .o_done(lp2done), .o_data(lp2data));
    // ----------------------------------------
    // clock, monitors, helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (dma_valid === 1'b1) got.push_back(dma_word);
        c1 <= c1 + (c1req === 1'b1);
        c2 <= c2 + (c2req === 1'b1);
        n1 <= n1 + (lp1req === 1'b1);
        n2 <= n2 + (lp2req === 1'b1);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [11:0] cval(input logic [7:0] e);
        return {e, e[7:4]} ^ 12'h5a3;
    endfunction
    function automatic logic [15:0] xword(input logic [1:0] m, input logic [7:0] e);
        logic [11:0] d;
        // resolution code 0..3 keeps 9..12 bits
        d = cval(e) & (12'hfff << (2'd3 - e[3:2]));
        return (m == `SAS_MODE_SINGLE) ? {e[7:4], d} : {1'b1, e[7:4], d[11:1]};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= w;
        rd_s <= !w;
        @(posedge clock);
        while (wait_s !== 1'b0 && n < 40) begin
            @(posedge clock);
            n++;
        end
        q = rdata;
        if (n == 40) num_errors++;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic toggle_ws(input int k);
        repeat (k) begin
            repeat (16) @(posedge clock);
            ws <= !ws;
        end
    endtask
    task automatic scan(input logic [1:0] m, input logic cv, input int len, input int r,
        input logic route);
        int b1, b2, x;
        logic [3:0] lm;
        b1 = c1;
        b2 = c2;
        x = len * r;
        lm = 4'(len - 1);
        got.delete();
        bus(1'b1, 8'(`SAS_REG_CTRL), {8'h00, r[7:0], 4'h0, lm, 1'b0, cv, m, 1'b0, route, 2'b01});
        toggle_ws(x + 1);
        repeat (30) @(posedge clock);
        `CHK(got.size(), route ? x : 0)
        for (int i = 0; i < got.size(); i++) begin
            if (m == `SAS_MODE_ALTER) `CHK(got[i][15], 1'(i % 2))
            else `CHK(got[i], xword(m, (cv || m != 0) ? tab2[i % len] : tab1[i % len]))
        end
        if (m == `SAS_MODE_ALTER) `CHK(c1 - b1 + c2 - b2, x)
        else begin
            `CHK(c1 - b1, (m != 0 || !cv) ? x : 0)
            `CHK(c2 - b2, (m != 0 || cv) ? x : 0)
        end
        `CHK(irq, irq_on)
        bus(1'b0, 8'(`SAS_REG_INT_STAT), 32'h0);
        `CHK(q[0], 1'b1)
        bus(1'b1, 8'(`SAS_REG_INT_CLR), 32'h1);
        repeat (3) @(posedge clock);
        `CHK(irq, 1'b0)
        $display("test scan mode %0d length %0d done", m, len);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {nrst, rd_s, wr_s, ws, deep, lps2, irq_on, addr, wdata} = '0;
        be = 4'hf;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        rd_chk(8'(`SAS_REG_CTRL), `SAS_CTRL_RESET);
        bus(1'b1, 8'h1f, 32'hffff_ffff);
        rd_chk(8'h1f, 32'h0);
        be <= 4'he;
        bus(1'b1, 8'(`SAS_REG_INT_EN), 32'h1);
        rd_chk(8'(`SAS_REG_INT_EN), 32'h0);
        be <= 4'hf;
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            tab1[i] = (i == 0) ? 8'hff : seed[7:0];
            tab2[i] = (i == 0) ? 8'h00 : seed[15:8];
            bus(1'b1, 8'h20 + 8'(i), {24'h0, tab1[i]});
            bus(1'b1, 8'h30 + 8'(i), {24'h0, tab2[i]});
        end
        for (int i = 0; i < 16; i++) begin
            rd_chk(8'h20 + 8'(i), {24'h0, tab1[i]});
            rd_chk(8'h30 + 8'(i), {24'h0, tab2[i]});
        end
        $display("test table done");
        bus(1'b1, 8'(`SAS_REG_INT_EN), 32'h1);
        irq_on = 1'b1;
        scan(`SAS_MODE_SINGLE, 1'b0, 3, 2, 1'b1);
        scan(`SAS_MODE_SINGLE, 1'b1, 16, 1, 1'b1);
        scan(`SAS_MODE_DOUBLE, 1'b0, 4, 1, 1'b1);
        scan(`SAS_MODE_ALTER, 1'b0, 4, 1, 1'b1);
        scan(`SAS_MODE_SINGLE, 1'b0, 1, 3, 1'b1);
        bus(1'b1, 8'(`SAS_REG_INT_EN), 32'h0);
        irq_on = 1'b0;
        scan(`SAS_MODE_SINGLE, 1'b0, 2, 1, 1'b0);
        b = c1;
        bus(1'b1, 8'(`SAS_REG_CTRL), 32'h0001_000c);
        toggle_ws(3);
        `CHK(c1 - b, 1)
        bus(1'b1, 8'(`SAS_REG_CTRL), `SAS_CTRL_RESET | 32'h2);
        $display("test trigger done");
        b = n1;
        bus(1'b1, 8'(`SAS_REG_LP_CTRL), 32'h0000_0051);
        repeat (20) @(posedge clock);
        `CHK(n1 - b, 1)
        rd_chk(8'(`SAS_REG_LP1_RES), {20'h0, cval(8'h50)});
        deep <= 1'b1;
        b = n2;
        bus(1'b1, 8'(`SAS_REG_LP_CTRL), 32'h0000_0a02);
        repeat (20) @(posedge clock);
        `CHK(n2 - b, 0)
        lps2 <= 1'b1;
        @(posedge clock);
        lps2 <= 1'b0;
        repeat (20) @(posedge clock);
        `CHK(n2 - b, 1)
        rd_chk(8'(`SAS_REG_LP2_RES), {20'h0, cval(8'ha0)});
        bus(1'b0, 8'(`SAS_REG_INT_STAT), 32'h0);
        `CHK(q[2:1], 2'b11)
        $display("test low power done");
        test_done;
    end
    initial begin
        repeat (30000) @(posedge clock);
        num_errors++;
        test_done;
    end
endmodule // tb_sas_scan_top
bind sas_scan_top sas_scan_top_properties sas_scan_top_properties_i (.*);
`default_nettype wire
